// >>> src/adcrw_cfg.svh
// Offsets, field positions, reset values and timing counts of the converter control block
`ifndef ADCRW_CFG_SVH
`define ADCRW_CFG_SVH
// ==========================================================
// Register indices (byte address = 4 * index)
`define ADCRW_IDX_CTRL_A      5'h00
`define ADCRW_IDX_CTRL_B      5'h01
`define ADCRW_IDX_CTRL_C      5'h02
`define ADCRW_IDX_CTRL_D      5'h03
`define ADCRW_IDX_CTRL_E      5'h04
`define ADCRW_IDX_SAMP_CTRL   5'h05
`define ADCRW_IDX_MUX         5'h06
`define ADCRW_IDX_COMMAND     5'h08
`define ADCRW_IDX_EV_CTRL     5'h09
`define ADCRW_IDX_INT_EN      5'h0A
`define ADCRW_IDX_INT_FLAGS   5'h0B
`define ADCRW_IDX_RESULT      5'h10
`define ADCRW_IDX_WIN_LOW     5'h12
`define ADCRW_IDX_WIN_HIGH    5'h14
// ==========================================================
// Field positions
`define ADCRW_BIT_ENABLE      0
`define ADCRW_BIT_FREERUN     1
`define ADCRW_BIT_RESSEL      2
`define ADCRW_BIT_RUNSTBY     7
`define ADCRW_BIT_SAMPLE_CAPACITANCE_SELECT     6
`define ADCRW_BIT_RESULT_READY_FLAG      0
`define ADCRW_BIT_WINDOW_COMPARE_FLAG       1
// ==========================================================
// Codes and reset values
`define ADCRW_REF_INTERNAL    2'h0
`define ADCRW_MUX_TEMP        5'h1E
`define ADCRW_RESET_BYTE      8'h00
`define ADCRW_VEC_RESULT_READY_FLAG      8'h00
`define ADCRW_VEC_WINDOW_COMPARE_FLAG       8'h02
// ==========================================================
// Timing in converter clock cycles
`define ADCRW_CONV_CYCLES     4'd13
`define ADCRW_SAMPLE_CYCLE    4'd1
`define ADCRW_INIT_DLY_UNIT   16
`endif

// >>> src/adcrw_pkg.sv
// Types shared by the converter control block
package adcrw_pkg;
	typedef enum logic [1:0] {ADCRW_IDLE, ADCRW_INIT_WAIT, ADCRW_CONVERT} adcrw_state_t;
	typedef enum logic [2:0] {
		ADCRW_WIN_OFF, ADCRW_WIN_BELOW, ADCRW_WIN_ABOVE, ADCRW_WIN_INSIDE, ADCRW_WIN_OUTSIDE
	} adcrw_win_t;
	typedef logic [15:0] adcrw_word_t;
endpackage : adcrw_pkg

// >>> src/adcrw_prescaler.sv
// Converter clock tick generator, held in reset while the sequencer idles or is powered down
`timescale 1ns/100ps
module adcrw_prescaler
(
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	input  wire logic       run_i,
	input  wire logic [2:0] presc_i,
	output logic            tick_o
);
	logic [7:0] count_reg;
	logic [7:0] last_w;

	assign last_w = 8'(({7'h00, 1'b1} << presc_i) << 1) - 8'h01;
	assign tick_o = run_i && (count_reg == last_w);

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i || !run_i || tick_o)
			count_reg <= 8'h00;
		else
			count_reg <= count_reg + 8'h01;
	end
endmodule : adcrw_prescaler

// >>> src/adcrw_sar.sv
// Ten-bit successive approximation register with ideal comparator
`timescale 1ns/100ps
module adcrw_sar
#(
	parameter int BITS = 10
)
(
	input  wire logic            clock_i,
	input  wire logic            rst_n_i,
	input  wire logic            load_i,
	input  wire logic            step_i,
	input  wire logic [15:0]     vin_i,
	input  wire logic [15:0]     vref_i,
	output logic      [BITS-1:0] code_o
);
	localparam logic [BITS-1:0] TOP = {1'b1, {(BITS-1){1'b0}}};
	localparam logic [BITS-1:0] FULL = {BITS{1'b1}};
	logic [15:0]     held_reg;
	logic [BITS-1:0] mask_reg;
	logic [BITS-1:0] trial_w;
	logic [31:0]     lhs_w;
	logic [31:0]     rhs_w;

	initial
	begin
		if (BITS < 2 || BITS > 14)
			$error("adcrw_sar: BITS out of range");
	end

	assign trial_w = code_o | mask_reg;
	// Above-reference input keeps every bit set, so it clamps to full scale
	assign lhs_w = 32'(held_reg) * 32'(FULL);
	assign rhs_w = 32'(trial_w) * 32'(vref_i);

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			held_reg <= 16'h0000;
			mask_reg <= '0;
			code_o   <= '0;
		end
		else if (load_i)
		begin
			held_reg <= vin_i;
			mask_reg <= TOP;
			code_o   <= '0;
		end
		else if (step_i && mask_reg != '0)
		begin
			if (lhs_w >= rhs_w)
				code_o <= trial_w;
			mask_reg <= mask_reg >> 1;
		end
	end
endmodule : adcrw_sar

// >>> src/adcrw_ctrl.sv
// Converter control: Wishbone registers, conversion sequencing, window compare, sleep
// Function
// - Free-running: already-started next result uses old channel, later ones the new.
// - Input above the reference gives the full-scale code 0x3FF.
// - Reference select chooses supply voltage or internal reference.
// - Result equals input times 1023 over reference once result-ready is set.
// - Reference select zero picks the internal reference.
// - Temperature channel code also switches the temperature sensor on.
// - Window flag rises below, above, inside or outside per mode.
// - Window mode zero disables compare; thresholds come from low/high registers.
// - With accumulation, compare only after the last sample, once per conversion.
// - Start-event enable lets an event start a conversion.
// - Two vectors: result-ready at offset zero, window compare at offset two.
// - Each condition sets its own flag and has its own enable bit.
// - Request stays high while flag and enable are both one.
// - Standby stops the converter unless run-in-standby is set.
// - Entering standby with run-in-standby lets a running conversion finish.
// - Clock requested only while a conversion needs it, released after completion.
// - Event rising edge sets the start bit; completion sets ready, clears start (here only when not free-running).
// - Non-zero initial delay postpones the first conversion after activation.
// - Power-down freezes conversion; on wake it completes and sets result-ready.
// - Result-ready clears on result read or writing one to the flag.
// - A conversion lasts thirteen converter clock cycles.
// - Channel and reference latch at start, follow registers in the last cycle.
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
`include "adcrw_cfg.svh"
module adcrw_ctrl
#(
	parameter int RES_BITS = 10
)
(
	input  wire logic         clock_i,
	input  wire logic         rst_n_i,
	input  wire logic         wb_cyc_i,
	input  wire logic         wb_stb_i,
	input  wire logic         wb_we_i,
	input  wire logic [7:0]   wb_adr_i,
	input  wire logic [3:0]   wb_sel_i,
	input  wire logic [31:0]  wb_dat_i,
	output logic      [31:0]  wb_dat_o,
	output logic              wb_ack_o,
	input  wire logic         start_event_i,
	input  wire logic         sleep_standby_i,
	input  wire logic         sleep_powerdown_i,
	input  wire adcrw_pkg::adcrw_word_t vin_mv_i,
	input  wire adcrw_pkg::adcrw_word_t vdd_mv_i,
	input  wire adcrw_pkg::adcrw_word_t vref_int_mv_i,
	output logic      [4:0]   channel_select_o,
	output logic      [1:0]   reference_select_o,
	output logic              sample_capacitance_select_o,
	output logic              temp_sensor_enable_o,
	output logic              clock_request_o,
	output logic              result_ready_irq_o,
	output logic              window_compare_irq_o,
	output logic      [7:0]   irq_vector_o
);
	import adcrw_pkg::*;

	initial
	begin
		if (RES_BITS != 10)
			$error("adcrw_ctrl: only ten-bit conversion is served");
	end

	// ==========================================================
	// Register state
	logic [7:0]   ctrl_a_reg;
	logic [2:0]   samp_num_reg;
	logic [7:0]   ctrl_c_reg;
	logic [2:0]   initial_delay_field;
	logic [2:0]   window_mode_field;
	logic [4:0]   sample_length_field;
	logic [4:0]   input_channel_select;
	logic         start_conversion_bit;
	logic         start_event_enable;
	logic [1:0]   interrupt_enable_register;
	logic         result_ready_flag;
	logic         window_compare_flag;
	adcrw_word_t  conversion_result;
	adcrw_word_t  window_low_threshold;
	adcrw_word_t  window_high_threshold;
	logic         ack_reg;
	logic [31:0]  rdata_reg;

	logic         enable_w;
	logic         freerun_w;
	logic [4:0]   index_w;
	logic         access_w;
	logic         wr_w;
	logic         rd_w;
	logic         wr_b0_w;
	logic         wr_b1_w;

	assign enable_w  = ctrl_a_reg[`ADCRW_BIT_ENABLE];
	assign freerun_w = ctrl_a_reg[`ADCRW_BIT_FREERUN];
	assign index_w   = wb_adr_i[6:2];
	assign access_w  = wb_cyc_i && wb_stb_i && ack_reg;
	assign wr_w      = access_w && wb_we_i;
	assign rd_w      = access_w && !wb_we_i;
	assign wr_b0_w   = wr_w && wb_sel_i[0];
	assign wr_b1_w   = wr_w && wb_sel_i[1];
	assign wb_ack_o  = ack_reg;
	assign wb_dat_o  = rdata_reg;

	// ==========================================================
	// Sequencer state
	adcrw_state_t state_reg;
	logic [3:0]   cycle_reg;
	logic [10:0]  delay_reg;
	logic [6:0]   samples_left_reg;
	logic [15:0]  accum_reg;
	logic         event_prev_reg;
	logic         standby_prev_reg;
	logic         enable_prev_reg;
	logic         first_conv_reg;
	logic [4:0]   mux_latch_reg;
	logic [1:0]   ref_latch_reg;
	logic         tick_w;
	logic         halted_w;
	logic         stopped_w;
	logic         run_w;
	logic         last_cycle_w;
	logic         sample_done_w;
	logic         conv_done_w;
	logic [9:0]   code_w;
	logic [15:0]  sample_w;
	logic [15:0]  sum_w;
	logic [15:0]  vref_w;
	logic         win_hit_w;
	logic         event_rise_w;
	logic         start_pending_w;

	// Power-down halts the sequencer in place
	assign halted_w = sleep_powerdown_i;
	// Standby without run-in-standby stops like a disable, but lets a running conversion finish
	assign stopped_w = !enable_w || (sleep_standby_i && !ctrl_a_reg[`ADCRW_BIT_RUNSTBY]);
	assign run_w = (state_reg != ADCRW_IDLE) && !halted_w;
	assign last_cycle_w = (cycle_reg == `ADCRW_CONV_CYCLES - 4'd1);
	assign sample_done_w = (state_reg == ADCRW_CONVERT) && tick_w && last_cycle_w;
	assign conv_done_w = sample_done_w && (samples_left_reg == 7'd1);
	assign event_rise_w = start_event_i && !event_prev_reg;
	assign start_pending_w = start_conversion_bit && !stopped_w && !halted_w;
	// Ideal comparator against the chosen reference; select zero is internal
	assign vref_w = (ref_latch_reg == `ADCRW_REF_INTERNAL) ? vref_int_mv_i : vdd_mv_i;
	assign sample_w = ctrl_a_reg[`ADCRW_BIT_RESSEL] ? {8'h00, code_w[9:2]} : {6'h00, code_w};
	assign sum_w = accum_reg + sample_w;

	adcrw_prescaler u_prescaler
	(
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.run_i   (run_w),
		.presc_i (ctrl_c_reg[2:0]),
		.tick_o  (tick_w)
	);

	adcrw_sar #(.BITS(10)) u_sar
	(
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.load_i  ((state_reg == ADCRW_CONVERT) && tick_w && cycle_reg == `ADCRW_SAMPLE_CYCLE),
		.step_i  ((state_reg == ADCRW_CONVERT) && tick_w && cycle_reg > `ADCRW_SAMPLE_CYCLE),
		.vin_i   (vin_mv_i),
		.vref_i  (vref_w),
		.code_o  (code_w)
	);

	// ==========================================================
	// Window comparator on the finished result
	always_comb
	begin
		case (window_mode_field)
			3'd1: win_hit_w = sum_w < window_low_threshold;
			3'd2: win_hit_w = sum_w > window_high_threshold;
			3'd3: win_hit_w = sum_w > window_low_threshold && sum_w < window_high_threshold;
			3'd4: win_hit_w = sum_w < window_low_threshold || sum_w > window_high_threshold;
			default: win_hit_w = 1'b0;
		endcase
	end

	// ==========================================================
	// Wishbone slave: one wait state, ack for one cycle, unmapped reads zero
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			ack_reg <= 1'b0;
		else
			ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			rdata_reg <= 32'h0000_0000;
		else if (wb_cyc_i && wb_stb_i && !ack_reg)
		begin
			if (index_w == `ADCRW_IDX_CTRL_A)
				rdata_reg <= {24'h00_0000, ctrl_a_reg};
			else if (index_w == `ADCRW_IDX_CTRL_B)
				rdata_reg <= {29'h0000_0000, samp_num_reg};
			else if (index_w == `ADCRW_IDX_CTRL_C)
				rdata_reg <= {24'h00_0000, ctrl_c_reg};
			else if (index_w == `ADCRW_IDX_CTRL_D)
				rdata_reg <= {24'h00_0000, initial_delay_field, 5'h00};
			else if (index_w == `ADCRW_IDX_CTRL_E)
				rdata_reg <= {29'h0000_0000, window_mode_field};
			else if (index_w == `ADCRW_IDX_SAMP_CTRL)
				rdata_reg <= {27'h000_0000, sample_length_field};
			else if (index_w == `ADCRW_IDX_MUX)
				rdata_reg <= {27'h000_0000, input_channel_select};
			else if (index_w == `ADCRW_IDX_COMMAND)
				rdata_reg <= {31'h0000_0000, start_conversion_bit};
			else if (index_w == `ADCRW_IDX_EV_CTRL)
				rdata_reg <= {31'h0000_0000, start_event_enable};
			else if (index_w == `ADCRW_IDX_INT_EN)
				rdata_reg <= {30'h0000_0000, interrupt_enable_register};
			else if (index_w == `ADCRW_IDX_INT_FLAGS)
				rdata_reg <= {30'h0000_0000, window_compare_flag, result_ready_flag};
			else if (index_w == `ADCRW_IDX_RESULT)
				rdata_reg <= {16'h0000, conversion_result};
			else if (index_w == `ADCRW_IDX_WIN_LOW)
				rdata_reg <= {16'h0000, window_low_threshold};
			else if (index_w == `ADCRW_IDX_WIN_HIGH)
				rdata_reg <= {16'h0000, window_high_threshold};
			else
				rdata_reg <= 32'h0000_0000;
		end
	end

	// ==========================================================
	// Configuration registers
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			ctrl_a_reg                <= `ADCRW_RESET_BYTE;
			samp_num_reg              <= 3'h0;
			ctrl_c_reg                <= `ADCRW_RESET_BYTE;
			initial_delay_field       <= 3'h0;
			window_mode_field         <= 3'h0;
			sample_length_field       <= 5'h00;
			input_channel_select      <= 5'h00;
			start_event_enable        <= 1'b0;
			interrupt_enable_register <= 2'h0;
			window_low_threshold      <= 16'h0000;
			window_high_threshold     <= 16'h0000;
		end
		else if (wr_b0_w)
		begin
			if (index_w == `ADCRW_IDX_CTRL_A)
				ctrl_a_reg <= wb_dat_i[7:0] & 8'h87;
			else if (index_w == `ADCRW_IDX_CTRL_B)
				samp_num_reg <= wb_dat_i[2:0];
			else if (index_w == `ADCRW_IDX_CTRL_C)
				ctrl_c_reg <= wb_dat_i[7:0] & 8'h77;
			else if (index_w == `ADCRW_IDX_CTRL_D)
				initial_delay_field <= wb_dat_i[7:5];
			else if (index_w == `ADCRW_IDX_CTRL_E)
				window_mode_field <= wb_dat_i[2:0];
			else if (index_w == `ADCRW_IDX_SAMP_CTRL)
				sample_length_field <= wb_dat_i[4:0];
			else if (index_w == `ADCRW_IDX_MUX)
				input_channel_select <= wb_dat_i[4:0];
			else if (index_w == `ADCRW_IDX_EV_CTRL)
				start_event_enable <= wb_dat_i[0];
			else if (index_w == `ADCRW_IDX_INT_EN)
				interrupt_enable_register <= wb_dat_i[1:0];
			else if (index_w == `ADCRW_IDX_WIN_LOW)
				window_low_threshold <= {wr_b1_w ? wb_dat_i[15:8] : window_low_threshold[15:8],
					wb_dat_i[7:0]};
			else if (index_w == `ADCRW_IDX_WIN_HIGH)
				window_high_threshold <= {wr_b1_w ? wb_dat_i[15:8] : window_high_threshold[15:8],
					wb_dat_i[7:0]};
		end
		else if (wr_b1_w)
		begin
			if (index_w == `ADCRW_IDX_WIN_LOW)
				window_low_threshold[15:8] <= wb_dat_i[15:8];
			else if (index_w == `ADCRW_IDX_WIN_HIGH)
				window_high_threshold[15:8] <= wb_dat_i[15:8];
		end
	end

	// ==========================================================
	// Start bit: software or event sets, completion clears unless free-running
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			start_conversion_bit <= 1'b0;
		else if (!enable_w)
			start_conversion_bit <= 1'b0;
		else if ((wr_b0_w && index_w == `ADCRW_IDX_COMMAND && wb_dat_i[0])
			|| (start_event_enable && event_rise_w))
			start_conversion_bit <= 1'b1;
		else if (conv_done_w && !freerun_w)
			start_conversion_bit <= 1'b0;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			event_prev_reg   <= 1'b0;
			standby_prev_reg <= 1'b0;
			enable_prev_reg  <= 1'b0;
		end
		else
		begin
			event_prev_reg   <= start_event_i;
			standby_prev_reg <= sleep_standby_i;
			enable_prev_reg  <= enable_w;
		end
	end

	// Settling delay is owed after enabling or on activation in standby
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			first_conv_reg <= 1'b0;
		else if ((enable_w && !enable_prev_reg) || (sleep_standby_i && !standby_prev_reg))
			first_conv_reg <= 1'b1;
		else if (state_reg == ADCRW_CONVERT)
			first_conv_reg <= 1'b0;
	end

	// ==========================================================
	// Sequencer
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			state_reg        <= ADCRW_IDLE;
			cycle_reg        <= 4'd0;
			delay_reg        <= 11'd0;
			samples_left_reg <= 7'd0;
			accum_reg        <= 16'h0000;
		end
		else if (!enable_w || (stopped_w && state_reg != ADCRW_CONVERT))
			state_reg <= ADCRW_IDLE;
		else if (!halted_w)
		begin
			case (state_reg)
				ADCRW_IDLE:
				begin
					cycle_reg        <= 4'd0;
					accum_reg        <= 16'h0000;
					samples_left_reg <= 7'(7'd1 << ((samp_num_reg > 3'd6) ? 3'd6 : samp_num_reg));
					delay_reg        <= 11'(initial_delay_field * `ADCRW_INIT_DLY_UNIT);
					if (start_pending_w)
						state_reg <= (first_conv_reg && initial_delay_field != 3'h0)
							? ADCRW_INIT_WAIT : ADCRW_CONVERT;
				end
				ADCRW_INIT_WAIT:
				begin
					if (tick_w)
					begin
						delay_reg <= delay_reg - 11'd1;
						if (delay_reg == 11'd1)
							state_reg <= ADCRW_CONVERT;
					end
				end
				ADCRW_CONVERT:
				begin
					// Running conversion finishes even if standby stops the block
					if (tick_w)
						cycle_reg <= last_cycle_w ? 4'd0 : cycle_reg + 4'd1;
					if (sample_done_w)
					begin
						samples_left_reg <= samples_left_reg - 7'd1;
						accum_reg        <= sum_w;
						if (conv_done_w)
							state_reg <= (freerun_w && !stopped_w) ? ADCRW_CONVERT : ADCRW_IDLE;
						if (conv_done_w)
						begin
							accum_reg        <= 16'h0000;
							samples_left_reg <= 7'(7'd1 << ((samp_num_reg > 3'd6) ? 3'd6 : samp_num_reg));
						end
					end
				end
				default: state_reg <= ADCRW_IDLE;
			endcase
		end
	end

	// Selections track registers except while locked mid-conversion
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			mux_latch_reg <= 5'h00;
			ref_latch_reg <= `ADCRW_REF_INTERNAL;
		end
		else if (state_reg != ADCRW_CONVERT || last_cycle_w)
		begin
			mux_latch_reg <= input_channel_select;
			ref_latch_reg <= ctrl_c_reg[5:4];
		end
	end

	// ==========================================================
	// Result and flags; a hardware set beats a clear in the same cycle
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			conversion_result <= 16'h0000;
		else if (conv_done_w)
			conversion_result <= sum_w;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			result_ready_flag <= 1'b0;
		else if (conv_done_w)
			result_ready_flag <= 1'b1;
		else if ((rd_w && index_w == `ADCRW_IDX_RESULT)
			|| (wr_b0_w && index_w == `ADCRW_IDX_INT_FLAGS && wb_dat_i[`ADCRW_BIT_RESULT_READY_FLAG]))
			result_ready_flag <= 1'b0;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			window_compare_flag <= 1'b0;
		else if (conv_done_w && win_hit_w)
			window_compare_flag <= 1'b1;
		else if (wr_b0_w && index_w == `ADCRW_IDX_INT_FLAGS && wb_dat_i[`ADCRW_BIT_WINDOW_COMPARE_FLAG])
			window_compare_flag <= 1'b0;
	end

	// ==========================================================
	// Outputs
	assign result_ready_irq_o   = result_ready_flag && interrupt_enable_register[0];
	assign window_compare_irq_o = window_compare_flag && interrupt_enable_register[1];
	assign irq_vector_o = result_ready_irq_o ? `ADCRW_VEC_RESULT_READY_FLAG : `ADCRW_VEC_WINDOW_COMPARE_FLAG;
	assign channel_select_o     = mux_latch_reg;
	assign reference_select_o   = ref_latch_reg;
	assign sample_capacitance_select_o = ctrl_c_reg[`ADCRW_BIT_SAMPLE_CAPACITANCE_SELECT];
	assign temp_sensor_enable_o = enable_w && (mux_latch_reg == `ADCRW_MUX_TEMP);
	assign clock_request_o      = (state_reg != ADCRW_IDLE) || start_pending_w;
endmodule : adcrw_ctrl

// >>> tb/adcrw_checker.sv
// Port checker of the converter control block
`timescale 1ns/100ps
module adcrw_checker
(
	input wire logic        clock_i,
	input wire logic        rst_n_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [4:0]  channel_select_o,
	input wire logic        temp_sensor_enable_o,
	input wire logic        result_ready_irq_o,
	input wire logic        window_compare_irq_o,
	input wire logic [7:0]  irq_vector_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// ==========
	// Bus handshake
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ans;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	a_ack_one_wait: assert property (s_req |=> s_ans)
		else $error("ack not one cycle after request");
	a_ack_from_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	// Read data must not drift between requests
	a_dat_idle_hold: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
		else $error("read data moved while idle");
	// ==========
	// Interrupts and sensor
	a_vec_ready_zero: assert property (result_ready_irq_o |-> irq_vector_o == 8'h00)
		else $error("vector wrong for ready");
	a_vec_window_two: assert property (!result_ready_irq_o |-> irq_vector_o == 8'h02)
		else $error("vector wrong for window");
	a_temp_on_chan: assert property (temp_sensor_enable_o |-> channel_select_o == 5'h1E)
		else $error("sensor on for wrong channel");
	a_rdy_irq_hold: assert property ($fell(result_ready_irq_o) |-> $past(wb_ack_o))
		else $error("ready request dropped on its own");
	a_win_irq_hold: assert property ($fell(window_compare_irq_o) |-> $past(wb_ack_o))
		else $error("window request dropped on its own");
endmodule : adcrw_checker

// >>> tb/adcrw_far_side.sv
// Analog inputs and event trigger facing the converter
`timescale 1ns/100ps
module adcrw_far_side
(
	input  wire logic                   clock_i,
	input  wire logic [4:0]             chan_i,
	input  wire logic                   fire_i,
	output adcrw_pkg::adcrw_word_t      vin_o,
	output adcrw_pkg::adcrw_word_t      vdd_o,
	output adcrw_pkg::adcrw_word_t      vref_o,
	output logic                        event_o
);
	import adcrw_pkg::*;
	// 100 mV per channel number, so high channels exceed the reference
	assign vin_o = 16'(chan_i) * 16'h0064;
	assign vdd_o = 16'h0CE4;
	assign vref_o = 16'h07D0;
	// Registered so the edge lands clear of the bus edge
	always_ff @(posedge clock_i)
		event_o <= fire_i;
endmodule : adcrw_far_side

// >>> tb/tb_top.sv
// Register level testbench of the converter control block
`timescale 1ns/100ps
module tb_top;
	import adcrw_pkg::*;
	logic        clk, rst_n, cyc, stb, we, fire, evt, sb, pd;
	logic        ack, rq, rirq, wirq, tsen, cap;
	logic [7:0]  adr, vec;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, q;
	logic [4:0]  ch;
	logic [1:0]  rsel;
	adcrw_word_t vin, vdd, vri;
	logic [4:0]  chs [3] = '{5'h05, 5'h13, 5'h1F};
	logic [5:0]  pat [2] = '{6'h08, 6'h14};
	int          n_mismatch = 0;
	int          n_tests = 0;

	adcrw_ctrl DUT (.clock_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .start_event_i(evt), .sleep_standby_i(sb),
		.sleep_powerdown_i(pd), .vin_mv_i(vin), .vdd_mv_i(vdd), .vref_int_mv_i(vri),
		.channel_select_o(ch), .reference_select_o(rsel), .sample_capacitance_select_o(cap),
		.temp_sensor_enable_o(tsen), .clock_request_o(rq), .result_ready_irq_o(rirq),
		.window_compare_irq_o(wirq), .irq_vector_o(vec));
	adcrw_far_side FAR (.clock_i(clk), .chan_i(ch), .fire_i(fire), .vin_o(vin),
		.vdd_o(vdd), .vref_o(vri), .event_o(evt));

	// ==========
	// Helpers
	task automatic test_done();
		$display("mismatches %0d of %0d checks", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [4:0] i, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {1'b0, i, 2'b00};
		wdat <= d;
		do
			@(posedge clk);
		while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	task automatic wait_rdy();
		int k;
		k = 0;
		do
		begin
			bus(0, 5'h0B, 0);
			k++;
		end
		while (q[0] !== 1'b1 && k < 100);
		chk("ready flag", 1, q[0]);
	endtask : wait_rdy
	task automatic conv(input logic [4:0] c);
		bus(1, 5'h06, {27'h0, c});
		bus(1, 5'h0B, 3);
		bus(1, 5'h08, 1);
		wait_rdy();
	endtask : conv
	// Ideal code against the 2000 mV internal reference
	function automatic logic [31:0] expc(input int c);
		int v;
		v = c * 100 * 1023 / 2000;
		return (v > 1023) ? 1023 : v;
	endfunction : expc

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		test_done();
	end
	initial
	begin
		int k;
		{rst_n, cyc, stb, we, fire, sb, pd, adr, wdat} = '0;
		sel = 4'hF;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		bus(0, 5'h00, 0);
		chk("control reset", 0, q);
		bus(1, 5'h02, 32'h50);
		bus(1, 5'h00, 1);
		chk("reference select", 1, rsel);
		chk("sample capacitance", 1, cap);
		bus(1, 5'h02, 0);
		bus(1, 5'h0A, 3);
		chk("reference select", 0, rsel);
		foreach (chs[j])
		begin
			conv(chs[j]);
			chk("vector", 8'h00, vec);
			bus(0, 5'h08, 0);
			chk("start bit", 0, q[0]);
			bus(0, 5'h10, 0);
			chk("result", expc(chs[j]), q);
			bus(0, 5'h0B, 0);
			chk("ready cleared", 0, q[0]);
			chk("vector", 8'h02, vec);
			chk("clock request", 0, rq);
		end
		bus(1, 5'h12, 32'h64);
		bus(1, 5'h14, 32'h012C);
		for (int n = 0; n < 2; n++)
			for (int m = 0; m < 6; m++)
			begin
				bus(1, 5'h04, m);
				conv(n ? 5'h1F : 5'h05);
				bus(0, 5'h0B, 0);
				chk("window flag", pat[n][m], q[1]);
				chk("window request", pat[n][m], wirq);
			end
		bus(1, 5'h0B, 2);
		@(posedge clk);
		chk("window request", 0, wirq);
		bus(1, 5'h00, 5);
		conv(5'h05);
		bus(0, 5'h10, 0);
		chk("result 8 bit", expc(5) >> 2, q);
		// One edge to leave idle, 13 ticks of two clocks, one edge to see it drop
		bus(1, 5'h08, 1);
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (rq === 1'b1 && k < 100);
		chk("conversion clocks", 13 * 2 + 2, k);
		bus(1, 5'h0B, 3);
		bus(1, 5'h08, 1);
		repeat (6) @(posedge clk);
		pd <= 1'b1;
		repeat (40) @(posedge clk);
		bus(0, 5'h0B, 0);
		chk("frozen ready", 0, q[0]);
		chk("frozen request", 1, rq);
		pd <= 1'b0;
		wait_rdy();
		sb <= 1'b1;
		bus(1, 5'h0B, 3);
		bus(1, 5'h08, 1);
		repeat (60) @(posedge clk);
		bus(0, 5'h0B, 0);
		chk("standby ready", 0, q[0]);
		chk("standby request", 0, rq);
		sb <= 1'b0;
		wait_rdy();
		bus(1, 5'h09, 1);
		bus(1, 5'h0B, 3);
		fire <= 1'b1;
		repeat (3) @(posedge clk);
		fire <= 1'b0;
		wait_rdy();
		bus(1, 5'h06, 32'h1E);
		bus(0, 5'h06, 0);
		chk("temp sensor", 1, tsen);
		test_done();
	end
endmodule : tb_top

bind adcrw_ctrl adcrw_checker u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.channel_select_o(channel_select_o), .temp_sensor_enable_o(temp_sensor_enable_o),
	.result_ready_irq_o(result_ready_irq_o), .window_compare_irq_o(window_compare_irq_o),
	.irq_vector_o(irq_vector_o));
